// *** rtl/ddr_read_capture_regs.svh ***
`ifndef DDR_READ_CAPTURE_REGS_SVH
`define DDR_READ_CAPTURE_REGS_SVH
// ==========================================
// sizes of the read path
`define RC_GROUP_WIDTH 9
`define RC_NUM_STROBES 4
`define RC_NUM_CHIPS 2
`define RC_FIFO_DEPTH 16
`define RC_PIPE_DEPTH 0
// ==========================================
// timing
`define RC_CLK_HZ 20000000
`define RC_STROBE_DELAY 4
`define RC_EVAL_TIME_S 3600
`define RC_EVAL_CYCLES (64'(`RC_EVAL_TIME_S) * 64'(`RC_CLK_HZ))
`endif

// *** rtl/ddr_read_capture_pkg.sv ***
package ddr_read_capture_pkg;
   // ==========================================
   // edge events of one sampled strobe
   typedef struct packed {
      logic rise;
      logic fall;
   } strobe_evt_t;

   // ==========================================
   // evaluation limit states
   typedef enum logic [1:0] {
      EVAL_COUNTING,
      EVAL_UNLIMITED,
      EVAL_EXPIRED
   } eval_state_t;
endpackage : ddr_read_capture_pkg

// *** rtl/capture_group.sv ***
`timescale 1ns/1ns
`default_nettype none
module capture_group #(
   parameter int WIDTH = 9
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire ddr_read_capture_pkg::strobe_evt_t strobe_evt,
   input wire logic [WIDTH-1:0] data_in,
   output logic [WIDTH-1:0] rise_q,
   output logic [WIDTH-1:0] fall_q
);
   import ddr_read_capture_pkg::*;

   // ==========================================
   // checks
   if (WIDTH < 1) begin : g_bad_width
      $error("capture_group: WIDTH must be at least 1");
   end

   // ==========================================
   // both beats held apart until the chip re-registers them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rise_q <= '0;
         fall_q <= '0;
      end else begin
         if (strobe_evt.rise) begin
            rise_q <= data_in;
         end
         if (strobe_evt.fall) begin
            fall_q <= data_in;
         end
      end
   end
endmodule : capture_group
`default_nettype wire

// *** rtl/stream_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module stream_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ==========================================
   // checks
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_fifo
      $error("stream_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;
   logic [AW:0] count_q;
   logic out_valid_q;
   logic [WIDTH-1:0] out_data_q;

   // ==========================================
   // handshakes; output stage is a register so the top sees flops
   wire logic push = in_valid && in_ready;
   wire logic pop = (count_q != '0) && (!out_valid_q || out_ready);
   assign in_ready = (count_q != (AW+1)'(DEPTH));
   assign out_valid = out_valid_q;
   assign out_data = out_data_q;

   // storage has no reset, pointers do
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wptr_q] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= rptr_q + 1'b1;
            out_data_q <= mem[rptr_q];
            out_valid_q <= 1'b1;
         end else if (out_ready) begin
            out_valid_q <= 1'b0;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : stream_fifo
`default_nettype wire

// *** rtl/ddr_read_capture_path.sv ***
// Behaviour
// - each data group captured by its own delayed strobe
// - chip valid flag captured by chip's first strobe
// - chip data re-registered on undelayed first strobe
// - one capture clock output per attached chip
// - rising beat low half, falling beat high
// - word bit ranges follow their capturing chip
// - read word twice the memory bus width
// - strobe inverted before clocking falling capture
// - group width set by parameter
// - limited run time unless tethered build
// - no read commands after evaluation expiry
// - shared time-out stops everything together
// - read pipeline equal depth, capture-clock timed
`include "ddr_read_capture_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module ddr_read_capture_path #(
   parameter int GROUP_WIDTH = `RC_GROUP_WIDTH,
   parameter int NUM_STROBES = `RC_NUM_STROBES,
   parameter int NUM_CHIPS = `RC_NUM_CHIPS,
   parameter int STROBE_DELAY = `RC_STROBE_DELAY,
   parameter int PIPE_DEPTH = `RC_PIPE_DEPTH,
   parameter int FIFO_DEPTH = `RC_FIFO_DEPTH,
   parameter bit TETHERED = 1'b0,
   parameter logic [63:0] EVAL_CYCLES = `RC_EVAL_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [NUM_STROBES-1:0] memory_read_strobe,
   input wire logic [GROUP_WIDTH*NUM_STROBES-1:0] mem_dq,
   input wire logic [NUM_CHIPS-1:0] mem_qvld,
   input wire logic read_cmd_req,
   input wire logic shared_timeout,
   output logic read_cmd_out,
   output logic eval_expired,
   output logic [NUM_CHIPS-1:0] capture_clk,
   output logic [2*GROUP_WIDTH*NUM_STROBES-1:0] rdata,
   output logic [NUM_CHIPS-1:0] rdata_chip_valid,
   output logic rdata_valid,
   input wire logic rdata_ready,
   output logic overflow
);
   import ddr_read_capture_pkg::*;

   localparam int DATA_W = GROUP_WIDTH * NUM_STROBES;
   localparam int WORD_W = 2 * DATA_W;
   localparam int SPC = NUM_STROBES / NUM_CHIPS;
   localparam int CHIP_W = SPC * GROUP_WIDTH;
   localparam int ENTRY_W = WORD_W + NUM_CHIPS;
   localparam int PD = (PIPE_DEPTH > 0) ? PIPE_DEPTH : 1;

   // ==========================================
   // elaboration checks
   if (GROUP_WIDTH < 1 || NUM_CHIPS < 1 || NUM_STROBES < NUM_CHIPS) begin : g_bad_size
      $error("ddr_read_capture_path: group or chip count out of range");
   end
   if (SPC * NUM_CHIPS != NUM_STROBES) begin : g_bad_split
      $error("ddr_read_capture_path: strobes must divide evenly among chips");
   end
   if (STROBE_DELAY < 1 || PIPE_DEPTH < 0 || EVAL_CYCLES == 64'h0) begin : g_bad_time
      $error("ddr_read_capture_path: delay, pipeline or evaluation count invalid");
   end

   // ==========================================
   // pin synchronisers, two stages each
   logic [NUM_STROBES-1:0] strobe_s1_q;
   logic [NUM_STROBES-1:0] strobe_s2_q;
   logic [DATA_W-1:0] dq_s1_q;
   logic [DATA_W-1:0] dq_s2_q;
   logic [NUM_CHIPS-1:0] qvld_s1_q;
   logic [NUM_CHIPS-1:0] qvld_s2_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         strobe_s1_q <= '0;
         strobe_s2_q <= '0;
         dq_s1_q <= '0;
         dq_s2_q <= '0;
         qvld_s1_q <= '0;
         qvld_s2_q <= '0;
      end else begin
         strobe_s1_q <= memory_read_strobe;
         strobe_s2_q <= strobe_s1_q;
         dq_s1_q <= mem_dq;
         dq_s2_q <= dq_s1_q;
         qvld_s1_q <= mem_qvld;
         qvld_s2_q <= qvld_s1_q;
      end
   end

   // ==========================================
   // strobe delay line: moves the capture point into the data eye
   logic [NUM_STROBES-1:0] dly_q [STROBE_DELAY];
   logic [NUM_STROBES-1:0] dly_prev_q;
   logic [NUM_STROBES-1:0] undly_prev_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < STROBE_DELAY; i++) begin
            dly_q[i] <= '0;
         end
         dly_prev_q <= '0;
         undly_prev_q <= '0;
      end else begin
         dly_q[0] <= strobe_s2_q;
         for (int i = 1; i < STROBE_DELAY; i++) begin
            dly_q[i] <= dly_q[i-1];
         end
         dly_prev_q <= dly_q[STROBE_DELAY-1];
         undly_prev_q <= strobe_s2_q;
      end
   end

   // edge decode; falling beat is the rising edge of the inverted strobe
   wire logic [NUM_STROBES-1:0] dly_strobe = dly_q[STROBE_DELAY-1];
   wire logic [NUM_STROBES-1:0] dly_strobe_inv = ~dly_strobe;
   wire logic [NUM_STROBES-1:0] dly_prev_inv = ~dly_prev_q;
   wire logic [NUM_STROBES-1:0] dly_rise = dly_strobe & ~dly_prev_q;
   wire logic [NUM_STROBES-1:0] dly_fall = dly_strobe_inv & ~dly_prev_inv;
   wire logic [NUM_STROBES-1:0] undly_rise = strobe_s2_q & ~undly_prev_q;

   // undelayed rise retimed by one cycle: at a half period equal to the delay,
   // the falling capture lands on the same edge and would otherwise be missed
   logic [NUM_STROBES-1:0] undly_rise_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         undly_rise_q <= '0;
      end else begin
         undly_rise_q <= undly_rise;
      end
   end

   strobe_evt_t strobe_evt [NUM_STROBES];
   logic [DATA_W-1:0] rise_cap;
   logic [DATA_W-1:0] fall_cap;
   logic [NUM_CHIPS-1:0] vld_cap;

   // ==========================================
   // one capture group per strobe, width from the group parameter
   for (genvar g = 0; g < NUM_STROBES; g++) begin : g_group
      assign strobe_evt[g].rise = dly_rise[g];
      assign strobe_evt[g].fall = dly_fall[g];
      capture_group #(
         .WIDTH(GROUP_WIDTH)
      ) u_group (
         .sys_clk(sys_clk),
         .rst(rst),
         .strobe_evt(strobe_evt[g]),
         .data_in(dq_s2_q[g*GROUP_WIDTH +: GROUP_WIDTH]),
         .rise_q(rise_cap[g*GROUP_WIDTH +: GROUP_WIDTH]),
         .fall_q(fall_cap[g*GROUP_WIDTH +: GROUP_WIDTH])
      );
   end

   // ==========================================
   // per chip: valid capture, re-register, pipeline
   logic [NUM_CHIPS-1:0] chip_evt;
   logic [DATA_W-1:0] rise_word;
   logic [DATA_W-1:0] fall_word;

   for (genvar c = 0; c < NUM_CHIPS; c++) begin : g_chip
      localparam int LEAD = c * SPC; // strobe that owns the chip's valid flag

      // only the chip's first strobe samples its valid flag
      capture_group #(
         .WIDTH(1)
      ) u_valid (
         .sys_clk(sys_clk),
         .rst(rst),
         .strobe_evt(strobe_evt[LEAD]),
         .data_in(qvld_s2_q[c]),
         .rise_q(vld_cap[c]),
         .fall_q()
      );

      logic [CHIP_W-1:0] rr_rise_q;
      logic [CHIP_W-1:0] rr_fall_q;
      logic rr_vld_q;
      logic rr_evt_q;

      // undelayed lead strobe: both beats are stable by then
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            rr_rise_q <= '0;
            rr_fall_q <= '0;
            rr_vld_q <= 1'b0;
            rr_evt_q <= 1'b0;
         end else begin
            rr_evt_q <= undly_rise_q[LEAD] && vld_cap[c];
            if (undly_rise_q[LEAD]) begin
               rr_rise_q <= rise_cap[c*CHIP_W +: CHIP_W];
               rr_fall_q <= fall_cap[c*CHIP_W +: CHIP_W];
               rr_vld_q <= vld_cap[c];
            end
         end
      end

      if (PIPE_DEPTH == 0) begin : g_nopipe
         assign rise_word[c*CHIP_W +: CHIP_W] = rr_rise_q;
         assign fall_word[c*CHIP_W +: CHIP_W] = rr_fall_q;
         assign chip_evt[c] = rr_evt_q;
      end else begin : g_pipe
         logic [CHIP_W-1:0] p_rise_q [PD];
         logic [CHIP_W-1:0] p_fall_q [PD];
         logic [PD-1:0] p_vld_q;
         logic p_evt_q;

         // data and valid advance together on the capture clock
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               for (int i = 0; i < PD; i++) begin
                  p_rise_q[i] <= '0;
                  p_fall_q[i] <= '0;
               end
               p_vld_q <= '0;
               p_evt_q <= 1'b0;
            end else begin
               p_evt_q <= 1'b0;
               if (dly_rise[LEAD]) begin
                  p_rise_q[0] <= rr_rise_q;
                  p_fall_q[0] <= rr_fall_q;
                  p_vld_q[0] <= rr_vld_q;
                  for (int i = 1; i < PD; i++) begin
                     p_rise_q[i] <= p_rise_q[i-1];
                     p_fall_q[i] <= p_fall_q[i-1];
                     p_vld_q[i] <= p_vld_q[i-1];
                  end
                  p_evt_q <= (PD == 1) ? rr_vld_q : p_vld_q[PD-2];
               end
            end
         end

         assign rise_word[c*CHIP_W +: CHIP_W] = p_rise_q[PD-1];
         assign fall_word[c*CHIP_W +: CHIP_W] = p_fall_q[PD-1];
         assign chip_evt[c] = p_evt_q;
      end
   end

   // ==========================================
   // capture clock per chip, the delayed lead strobe
   logic [NUM_CHIPS-1:0] capture_clk_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         capture_clk_q <= '0;
      end else begin
         for (int c = 0; c < NUM_CHIPS; c++) begin
            capture_clk_q[c] <= dly_strobe[c*SPC];
         end
      end
   end

   // ==========================================
   // read word buffer; mask tells which chip ranges are fresh
   wire logic push_word = |chip_evt;
   wire logic [ENTRY_W-1:0] push_entry = {chip_evt, fall_word, rise_word};
   logic fifo_in_ready;
   logic [ENTRY_W-1:0] pop_entry;

   stream_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(push_word),
      .in_ready(fifo_in_ready),
      .in_data(push_entry),
      .out_valid(rdata_valid),
      .out_ready(rdata_ready),
      .out_data(pop_entry)
   );

   assign rdata = pop_entry[WORD_W-1:0];
   assign rdata_chip_valid = pop_entry[ENTRY_W-1:WORD_W];

   // memory cannot be stalled, so a lost word is flagged until reset
   logic overflow_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         overflow_q <= 1'b0;
      end else if (push_word && !fifo_in_ready) begin
         overflow_q <= 1'b1;
      end
   end

   // ==========================================
   // evaluation limit
   eval_state_t eval_state_q;
   eval_state_t eval_state_d;
   logic [63:0] eval_count_q;

   wire logic eval_last = (eval_count_q == EVAL_CYCLES - 64'h1);

   // next state; a shared time-out ends every mode at once
   always_comb begin
      eval_state_d = eval_state_q;
      case (eval_state_q)
         EVAL_COUNTING: begin
            if (shared_timeout || eval_last) begin
               eval_state_d = EVAL_EXPIRED;
            end
         end
         EVAL_UNLIMITED: begin
            if (shared_timeout) begin
               eval_state_d = EVAL_EXPIRED;
            end
         end
         EVAL_EXPIRED: begin
            eval_state_d = EVAL_EXPIRED;
         end
         default: begin
            eval_state_d = EVAL_EXPIRED;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         eval_state_q <= TETHERED ? EVAL_UNLIMITED : EVAL_COUNTING;
         eval_count_q <= 64'h0;
      end else begin
         eval_state_q <= eval_state_d;
         if (eval_state_q == EVAL_COUNTING) begin
            eval_count_q <= eval_count_q + 64'h1;
         end
      end
   end

   // ==========================================
   // read command gate: expiry and a full buffer both hold reads back
   wire logic eval_stop = (eval_state_d == EVAL_EXPIRED);
   logic read_cmd_q;
   logic eval_expired_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         read_cmd_q <= 1'b0;
         eval_expired_q <= 1'b0;
      end else begin
         read_cmd_q <= read_cmd_req && !eval_stop && fifo_in_ready;
         eval_expired_q <= eval_stop;
      end
   end

   assign read_cmd_out = read_cmd_q;
   assign eval_expired = eval_expired_q;
   assign capture_clk = capture_clk_q;
   assign overflow = overflow_q;
endmodule : ddr_read_capture_path
`default_nettype wire

// *** tb/ddr_read_capture_path_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module ddr_read_capture_path_assertions #(
   parameter int GROUP_WIDTH = 9,
   parameter int NUM_STROBES = 4,
   parameter int NUM_CHIPS = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [NUM_STROBES-1:0] memory_read_strobe,
   input wire logic [GROUP_WIDTH*NUM_STROBES-1:0] mem_dq,
   input wire logic [NUM_CHIPS-1:0] mem_qvld,
   input wire logic read_cmd_req,
   input wire logic shared_timeout,
   input wire logic read_cmd_out,
   input wire logic eval_expired,
   input wire logic [NUM_CHIPS-1:0] capture_clk,
   input wire logic [2*GROUP_WIDTH*NUM_STROBES-1:0] rdata,
   input wire logic [NUM_CHIPS-1:0] rdata_chip_valid,
   input wire logic rdata_valid,
   input wire logic rdata_ready,
   input wire logic overflow
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================
   // read command gating
   cmd_has_cause_a: assert property (read_cmd_out |-> $past(read_cmd_req))
      else $error("read command without request");
   expired_no_cmd_a: assert property (eval_expired |-> !read_cmd_out)
      else $error("read command after expiry");
   expired_sticky_a: assert property (eval_expired |=> eval_expired)
      else $error("expiry flag dropped");
   shared_stop_a: assert property (shared_timeout |=> eval_expired && !read_cmd_out)
      else $error("shared time-out ignored");
   // ==========================================
   // read words: held while stalled, always owned by some chip
   word_hold_a: assert property (rdata_valid && !rdata_ready |=>
      rdata_valid && $stable(rdata) && $stable(rdata_chip_valid))
      else $error("read word changed while stalled");
   word_owner_a: assert property (rdata_valid |-> rdata_chip_valid != '0)
      else $error("read word without owner");
   overflow_sticky_a: assert property (overflow |=> overflow)
      else $error("overflow flag dropped");
   // ==========================================
   // capture clocks follow each chip's lead strobe, not the others
   lead_zero_clk_a: assert property ($rose(memory_read_strobe[0]) |-> ##[5:8] capture_clk[0])
      else $error("capture clock 0 missing");
   lead_two_clk_a: assert property ($rose(memory_read_strobe[2]) |-> ##[5:8] capture_clk[1])
      else $error("capture clock 1 missing");
   clk_has_cause_a: assert property ($rose(capture_clk[1]) |-> $past(memory_read_strobe[2], 4))
      else $error("capture clock 1 without strobe");
   cover property (rdata_valid && rdata_chip_valid == '1);
   cover property ($rose(overflow));
   cover property ($rose(eval_expired));
endmodule : ddr_read_capture_path_assertions
bind ddr_read_capture_path ddr_read_capture_path_assertions #(.GROUP_WIDTH(GROUP_WIDTH),
   .NUM_STROBES(NUM_STROBES), .NUM_CHIPS(NUM_CHIPS)) u_ddr_read_capture_path_assertions (
   .sys_clk(sys_clk), .rst(rst), .memory_read_strobe(memory_read_strobe), .mem_dq(mem_dq),
   .mem_qvld(mem_qvld), .read_cmd_req(read_cmd_req), .shared_timeout(shared_timeout),
   .read_cmd_out(read_cmd_out), .eval_expired(eval_expired), .capture_clk(capture_clk),
   .rdata(rdata), .rdata_chip_valid(rdata_chip_valid), .rdata_valid(rdata_valid),
   .rdata_ready(rdata_ready), .overflow(overflow));
`default_nettype wire

// *** tb/chip_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module chip_model #(
   parameter int HALF_NS = 200,
   parameter int LAG_NS = 150
) (
   output logic [1:0] read_strobe,
   output logic [17:0] dq,
   output logic qvld
);
   // ==========================================
   // strobes stand low between frames
   initial begin
      read_strobe = 2'b00;
      dq = 18'h2D1B4;
      qvld = 1'b0;
   end
   // one frame: n valid periods and a trailing period that flushes the last one
   // data lags each strobe edge so the delayed strobe lands inside the beat
   task automatic burst(input int n, input logic [17:0] base);
      for (int k = 0; k <= n; k++) begin
         read_strobe = 2'b11;
         #LAG_NS;
         qvld = (k < n);
         dq = (k < n) ? base + 18'(k) : ~dq;
         #(HALF_NS - LAG_NS);
         read_strobe = 2'b00;
         #LAG_NS;
         dq = ~dq; // falling beat, never left at the last value
         #(HALF_NS - LAG_NS);
      end
   endtask : burst
endmodule : chip_model
`default_nettype wire

// *** tb/ddr_read_capture_path_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module ddr_read_capture_path_tb;
   import ddr_read_capture_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic read_cmd_req = 1'b0;
   logic shared_timeout = 1'b0;
   logic rdata_ready = 1'b0;
   logic read_cmd_out, eval_expired, overflow, rdata_valid;
   logic [1:0] capture_clk, rdata_chip_valid, m;
   logic [71:0] rdata, w;
   wire logic [3:0] memory_read_strobe;
   wire logic [35:0] mem_dq;
   wire logic [1:0] mem_qvld;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   // ==========================================
   // clock and design under test
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= rst ? 0 : cyc + 1;
   ddr_read_capture_path #(.EVAL_CYCLES(64'h258)) u_ddr_read_capture_path (
      .sys_clk(sys_clk), .rst(rst), .memory_read_strobe(memory_read_strobe),
      .mem_dq(mem_dq), .mem_qvld(mem_qvld), .read_cmd_req(read_cmd_req),
      .shared_timeout(shared_timeout), .read_cmd_out(read_cmd_out),
      .eval_expired(eval_expired), .capture_clk(capture_clk), .rdata(rdata),
      .rdata_chip_valid(rdata_chip_valid), .rdata_valid(rdata_valid),
      .rdata_ready(rdata_ready), .overflow(overflow));
   chip_model u_chip_model_0 (.read_strobe(memory_read_strobe[1:0]), .dq(mem_dq[17:0]),
      .qvld(mem_qvld[0]));
   chip_model u_chip_model_1 (.read_strobe(memory_read_strobe[3:2]), .dq(mem_dq[35:18]),
      .qvld(mem_qvld[1]));
   // ==========================================
   // shared helpers
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      $display("mismatches=%0d checks=%0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic do_reset;
      @(posedge sys_clk) rst <= 1'b1;
      repeat (9) @(posedge sys_clk);
      rst <= 1'b0;
   endtask : do_reset
   // next word with ready high; bounded so a lost word cannot hang the run
   task automatic get_word;
      int i;
      for (i = 0; i < 60; i++) begin
         @(negedge sys_clk);
         if (rdata_valid === 1'b1) break;
      end
      if (i == 60) begin
         error_cnt++;
         final_report();
      end
      w = rdata;
      m = rdata_chip_valid;
      @(posedge sys_clk);
   endtask : get_word
   // start strobes off the clock's phase, with the consumer stalled
   task automatic frame_start;
      @(posedge sys_clk) rdata_ready <= 1'b0;
      #13;
   endtask : frame_start
   // ==========================================
   // scenarios
   task automatic s_cmd;
      @(posedge sys_clk) read_cmd_req <= 1'b1;
      @(posedge sys_clk) read_cmd_req <= 1'b0;
      @(negedge sys_clk);
      chk(72'(read_cmd_out), 72'h1);
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(72'(read_cmd_out), 72'h0);
   endtask : s_cmd
   task automatic s_both;
      logic [17:0] a, b;
      frame_start();
      fork
         u_chip_model_0.burst(3, 18'h0A5C3);
         u_chip_model_1.burst(3, 18'h13E07);
      join
      @(posedge sys_clk) rdata_ready <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         a = 18'h0A5C3 + 18'(k);
         b = 18'h13E07 + 18'(k);
         get_word();
         chk(72'(m), 72'h3);
         chk(w, {~b, ~a, b, a});
      end
   endtask : s_both
   task automatic s_chip1;
      logic [17:0] b;
      frame_start();
      u_chip_model_1.burst(2, 18'h2F00D);
      @(posedge sys_clk) rdata_ready <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         b = 18'h2F00D + 18'(k);
         get_word();
         chk(72'(m), 72'h2);
         chk(72'({w[71:54], w[35:18]}), 72'({~b, b}));
      end
   endtask : s_chip1
   // fill past capacity while stalled, then drain to empty
   task automatic s_overflow;
      logic [17:0] a;
      @(posedge sys_clk) read_cmd_req <= 1'b1;
      frame_start();
      u_chip_model_0.burst(18, 18'h11111);
      repeat (8) @(negedge sys_clk);
      chk(72'(overflow), 72'h1);
      chk(72'(read_cmd_out), 72'h0);
      @(posedge sys_clk) rdata_ready <= 1'b1;
      for (int k = 0; k < 17; k++) begin
         a = 18'h11111 + 18'(k);
         get_word();
         chk(72'({m, w[53:36], w[17:0]}), 72'({2'b01, ~a, a}));
      end
      repeat (3) @(negedge sys_clk);
      chk(72'(rdata_valid), 72'h0);
      chk(72'(read_cmd_out), 72'h1);
   endtask : s_overflow
   task automatic s_expire;
      int i;
      for (i = 0; i < 1000; i++) begin
         @(negedge sys_clk);
         if (eval_expired === 1'b1) break;
      end
      if (i == 1000) begin
         error_cnt++;
         final_report();
      end
      chk(72'(cyc), 72'h258);
      chk(72'(read_cmd_out), 72'h0);
   endtask : s_expire
   task automatic s_shared;
      do_reset();
      repeat (2) @(negedge sys_clk);
      chk(72'({overflow, eval_expired, read_cmd_out}), 72'h1);
      @(posedge sys_clk) shared_timeout <= 1'b1;
      @(posedge sys_clk) shared_timeout <= 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(72'({eval_expired, read_cmd_out}), 72'h2);
   endtask : s_shared
   // ==========================================
   // main sequence
   initial begin
      do_reset();
      s_cmd();
      s_both();
      s_chip1();
      s_overflow();
      s_expire();
      s_shared();
      final_report();
   end
endmodule : ddr_read_capture_path_tb
`default_nettype wire
